// *** rtl/cier_map.vh ***
// Constants for the interrupt entry and return unit
`ifndef CIER_MAP_VH
`define CIER_MAP_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CIER_NSRC 8
`define CIER_PCW 16
`define CIER_SPW 16
`define CIER_VECW 16

// ----------------------------------------
// AXI4-Lite register byte offsets
// ----------------------------------------
`define CIER_OFF_ENABLE 8'h00
`define CIER_OFF_FLAGS 8'h04
`define CIER_OFF_STATUS 8'h08
`define CIER_OFF_CONTROL 8'h0C
`define CIER_OFF_SLEEPWAIT 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIER_ST_GIE 0
`define CIER_ST_BUSY 1
`define CIER_ST_VEC_LSB 8
`define CIER_CTL_LEVEL_LSB 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIER_RST_ENABLE 8'h00
`define CIER_RST_LEVEL 8'h00
`define CIER_RST_SLEEPWAIT 8'h00

// ----------------------------------------
// Timing counts in core cycles, then vector and stack pointer steps
// ----------------------------------------
`define CIER_ENTRY_CYC 4
`define CIER_WAKE_CYC 4
`define CIER_RET_CYC 4
`define CIER_JMP_CYC 3
`define CIER_VEC_STEP 16'h0002
`define CIER_SP_STEP 16'h0002

`endif

// *** rtl/cier_unit.v ***
// Interrupt entry and return sequencer with AXI4-Lite control registers
// Notes on behaviour
// - Reset and sources vectored lowest first
// - Accept only when individual and global enabled
// - Entry clears global enable
// - Software may re-enable for nesting
// - Return sets global enable
// - Vectoring clears the served flag
// - Writing one clears a flag
// - Flag held while individually disabled
// - Pending flags served by priority later
// - Level sources request only while present
// - One instruction after return before service
// - Status register never saved or restored
// - Disable instruction blocks same-cycle requests
// - One instruction after enable before service
// - Entry four cycles, pushing counter
// - Multi-cycle instruction completes before entry
// - Wake from sleep adds four cycles; the code first counts down sleepWait_r start-up cycles
// - Return four cycles, pops, sets enable
// - Vector jump takes three cycles
// - Single undivided core clock
// - Push decrements stack pointer by two
`include "cier_map.vh"
`timescale 1ns/1ps
`default_nettype none

module cier_unit (
	// Clock and reset
	input wire clock,
	input wire nrst,
	// Interrupt sources (asynchronous pins)
	input wire [`CIER_NSRC-1:0] srcEvent,
	// Instruction sequencer, same clock
	input wire instrBoundary,
	input wire instrRetiExec,
	input wire instrSeiExec,
	input wire instrCliExec,
	input wire instrGieWrite,
	input wire instrGieValue,
	input wire coreSleeping,
	input wire [`CIER_SPW-1:0] stackTopPointerIn,
	input wire [`CIER_PCW-1:0] pcIn,
	input wire [`CIER_PCW-1:0] popData,
	// Sequencer outputs
	output reg globalEnable,
	output reg irqHold,
	output reg pushValid,
	output reg [7:0] pushByte,
	output reg popReq,
	output reg [`CIER_SPW-1:0] stackTopPointerOut,
	output reg stackWrite,
	output reg [`CIER_PCW-1:0] pcOut,
	output reg pcLoad,
	output reg [3:0] servedVector,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// ----------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------
	reg rstS1_r, rstS2_r;
	wire rstN = rstS2_r;
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstS1_r <= 1'b0;
			rstS2_r <= 1'b0;
		end else begin
			rstS1_r <= 1'b1;
			rstS2_r <= rstS1_r;
		end
	end

	reg [`CIER_NSRC-1:0] srcS1_r, srcS2_r, srcLast_r;
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			srcS1_r <= 8'h00;
			srcS2_r <= 8'h00;
			srcLast_r <= 8'h00;
		end else begin
			srcS1_r <= srcEvent;
			srcS2_r <= srcS1_r;
			srcLast_r <= srcS2_r;
		end
	end

	// ----------------------------------------
	// State and registers
	// ----------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_WAKE = 2'h1;
	localparam ST_ENTRY = 2'h2;
	localparam ST_RET = 2'h3;

	reg [1:0] state_r;
	reg [2:0] cnt_r;
	reg [`CIER_NSRC-1:0] enable_r, level_r, flags_r;
	reg [7:0] sleepWait_r;
	reg [7:0] wakeCnt_r;
	reg holdOff_r;
	reg [2:0] srcSel_r;
	reg [`CIER_PCW-1:0] savedPc_r;

	// Flag sources latch rising edges; level sources follow the pin
	wire [`CIER_NSRC-1:0] edges = srcS2_r & ~srcLast_r;
	wire [`CIER_NSRC-1:0] request = (flags_r & ~level_r) | (srcS2_r & level_r);
	wire [`CIER_NSRC-1:0] armed = request & enable_r;

	// Lowest index equals lowest vector address after reset
	reg [2:0] winIdx;
	reg winAny;
	integer i;
	always @* begin
		winIdx = 3'h0;
		winAny = 1'b0;
		for (i = `CIER_NSRC - 1; i >= 0; i = i - 1) begin
			if (armed[i]) begin
				winIdx = i[2:0];
				winAny = 1'b1;
			end
		end
	end

	// Cli blocks even a coincident request; holdOff delays one instruction
	wire take = winAny && globalEnable && !instrCliExec && !holdOff_r
		&& instrBoundary && !instrRetiExec && state_r == ST_IDLE;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	reg awHave_r, wHave_r;
	reg [7:0] awAddr_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
	wire [`CIER_NSRC-1:0] clrMask = (doWrite && awAddr_r == `CIER_OFF_FLAGS && wStrb_r[0])
		? wData_r[7:0] : 8'h00;

	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
			enable_r <= `CIER_RST_ENABLE;
			level_r <= `CIER_RST_LEVEL;
			sleepWait_r <= `CIER_RST_SLEEPWAIT;
		end else begin
			s_axi_awready <= !awHave_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !wHave_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (awAddr_r)
					`CIER_OFF_ENABLE: begin
						if (wStrb_r[0])
							enable_r <= wData_r[7:0];
					end
					`CIER_OFF_CONTROL: begin
						if (wStrb_r[0])
							level_r <= wData_r[7:0];
					end
					`CIER_OFF_SLEEPWAIT: begin
						if (wStrb_r[0])
							sleepWait_r <= wData_r[7:0];
					end
					`CIER_OFF_FLAGS, `CIER_OFF_STATUS: ;
					default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr)
					`CIER_OFF_ENABLE: s_axi_rdata <= {24'h000000, enable_r};
					`CIER_OFF_FLAGS: s_axi_rdata <= {24'h000000, flags_r};
					`CIER_OFF_CONTROL: s_axi_rdata <= {24'h000000, level_r};
					`CIER_OFF_SLEEPWAIT: s_axi_rdata <= {24'h000000, sleepWait_r};
					`CIER_OFF_STATUS: s_axi_rdata <= {20'h00000, servedVector, 6'h00,
						state_r != ST_IDLE, globalEnable};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Flags: set wins over any clear
	// ----------------------------------------
	wire [`CIER_NSRC-1:0] hwClr = (state_r == ST_ENTRY && cnt_r == 3'h0)
		? (8'h01 << srcSel_r) & ~level_r : 8'h00;
	always @(posedge clock or negedge rstN) begin
		if (!rstN)
			flags_r <= 8'h00;
		else
			flags_r <= ((flags_r & ~clrMask & ~hwClr) | (edges & ~level_r));
	end

	// ----------------------------------------
	// Entry and return sequencer
	// ----------------------------------------
	// The status register is untouched: only the global enable bit lives here
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			wakeCnt_r <= 8'h00;
			globalEnable <= 1'b0;
			holdOff_r <= 1'b0;
			srcSel_r <= 3'h0;
			savedPc_r <= 16'h0000;
			irqHold <= 1'b0;
			pushValid <= 1'b0;
			pushByte <= 8'h00;
			popReq <= 1'b0;
			stackTopPointerOut <= 16'h0000;
			stackWrite <= 1'b0;
			pcOut <= 16'h0000;
			pcLoad <= 1'b0;
			servedVector <= 4'h0;
		end else begin
			pushValid <= 1'b0;
			popReq <= 1'b0;
			stackWrite <= 1'b0;
			pcLoad <= 1'b0;
			if (instrBoundary)
				holdOff_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (instrCliExec) begin
						globalEnable <= 1'b0;
					end else if (instrSeiExec) begin
						globalEnable <= 1'b1;
						holdOff_r <= 1'b1;
					end else if (instrGieWrite) begin
						globalEnable <= instrGieValue;
					end
					if (instrRetiExec) begin
						state_r <= ST_RET;
						cnt_r <= 3'h0;
						irqHold <= 1'b1;
						popReq <= 1'b1;
					end else if (take) begin
						globalEnable <= 1'b0;
						srcSel_r <= winIdx;
						savedPc_r <= pcIn;
						irqHold <= 1'b1;
						cnt_r <= 3'h0;
						wakeCnt_r <= sleepWait_r;
						state_r <= coreSleeping ? ST_WAKE : ST_ENTRY;
					end
				end
				ST_WAKE: begin
					// Start-up delay, then the extra four cycles
					if (wakeCnt_r != 8'h00) begin
						wakeCnt_r <= wakeCnt_r - 8'h01;
					end else if (cnt_r == `CIER_WAKE_CYC - 1) begin
						cnt_r <= 3'h0;
						state_r <= ST_ENTRY;
					end else begin
						cnt_r <= cnt_r + 3'h1;
					end
				end
				ST_ENTRY: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == 3'h0) begin
						pushValid <= 1'b1;
						pushByte <= savedPc_r[7:0];
					end else if (cnt_r == 3'h1) begin
						pushValid <= 1'b1;
						pushByte <= savedPc_r[15:8];
						stackTopPointerOut <= stackTopPointerIn - `CIER_SP_STEP;
						stackWrite <= 1'b1;
					end else if (cnt_r == `CIER_ENTRY_CYC - 1) begin
						// Reset owns vector 0, source n owns vector n+1
						pcOut <= {12'h000, {1'b0, srcSel_r} + 4'h1} * `CIER_VEC_STEP;
						pcLoad <= 1'b1;
						servedVector <= {1'b0, srcSel_r} + 4'h1;
						irqHold <= 1'b0;
						state_r <= ST_IDLE;
					end
				end
				ST_RET: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == 3'h1) begin
						stackTopPointerOut <= stackTopPointerIn + `CIER_SP_STEP;
						stackWrite <= 1'b1;
					end else if (cnt_r == `CIER_RET_CYC - 1) begin
						pcOut <= popData;
						pcLoad <= 1'b1;
						globalEnable <= 1'b1;
						holdOff_r <= 1'b1;
						irqHold <= 1'b0;
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
	// The vector holds a jump the sequencer runs in three cycles
	// Whole unit runs on the undivided core clock

endmodule // cier_unit
`default_nettype wire

// *** tb/cier_asserts.sv ***
// Concurrent checks on the interrupt entry and return unit ports
`timescale 1ns/1ps
`default_nettype none
module cier_asserts (
	// Clock, reset and sequencer inputs
	input wire logic clock,
	input wire logic nrst,
	input wire logic instrCliExec,
	input wire logic [15:0] stackTopPointerIn,
	input wire logic [15:0] pcIn,
	input wire logic [15:0] popData,
	// Sequencer outputs
	input wire logic globalEnable,
	input wire logic irqHold,
	input wire logic pushValid,
	input wire logic [7:0] pushByte,
	input wire logic popReq,
	input wire logic [15:0] stackTopPointerOut,
	input wire logic stackWrite,
	input wire logic [15:0] pcOut,
	input wire logic pcLoad,
	input wire logic [3:0] servedVector
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_push_order: assert property ($rose(pushValid) |-> pushByte == pcIn[7:0]
		##1 pushValid && pushByte == pcIn[15:8] ##1 !pushValid) else $error("bad push");
	a_entry_len: assert property ($rose(pushValid) |-> ##3 pcLoad)
		else $error("entry length wrong");
	a_entry_vector: assert property ($rose(pushValid) |-> ##3 pcOut == {11'h000, servedVector, 1'b0})
		else $error("wrong vector address");
	a_entry_gie: assert property ($rose(pushValid) |-> !globalEnable && irqHold)
		else $error("enable kept on entry");
	a_push_sp: assert property (pushValid && stackWrite |->
		stackTopPointerOut == stackTopPointerIn - 16'h0002) else $error("push pointer wrong");
	a_ret_sp: assert property (popReq |-> ##2 (stackWrite &&
		stackTopPointerOut == stackTopPointerIn + 16'h0002)) else $error("pop pointer wrong");
	a_ret_load: assert property (popReq |-> ##4 (pcLoad && pcOut == popData)
		##[0:1] globalEnable) else $error("return sequence wrong");
	a_cli_block: assert property (instrCliExec && !irqHold |=> !pushValid [*4])
		else $error("entry after disable");
endmodule // cier_asserts
bind cier_unit cier_asserts u_chk (.clock, .nrst, .instrCliExec, .stackTopPointerIn, .pcIn,
	.popData, .globalEnable, .irqHold, .pushValid, .pushByte, .popReq, .stackTopPointerOut,
	.stackWrite, .pcOut, .pcLoad, .servedVector);
`default_nettype wire

// *** tb/cier_seq_model.sv ***
// Instruction sequencer model facing the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module cier_seq_model (
	// From the unit
	input wire logic irqHold,
	// From the bench: a multi-cycle instruction is still running
	input wire logic stall,
	// To the unit
	output logic instrBoundary,
	output logic [15:0] pcIn,
	output logic [15:0] stackTopPointerIn,
	output logic [15:0] popData
);
	// Stalls its boundaries while the unit owns the core
	assign instrBoundary = (irqHold !== 1'b1) && !stall;
	assign pcIn = 16'h0123;
	assign stackTopPointerIn = 16'h02FF;
	assign popData = 16'h0456;
endmodule // cier_seq_model
`default_nettype wire

// *** tb/tb_cpu_interrupt_entry_return.sv ***
// Testbench for the interrupt entry and return unit
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_interrupt_entry_return;
	logic clock = 0, nrst = 0, instrRetiExec = 0, instrSeiExec = 0, instrCliExec = 0;
	logic instrGieWrite = 0, instrGieValue = 0, coreSleeping = 0, instrBoundary;
	logic stall = 0;
	logic [7:0] srcEvent = 0, s_axi_awaddr = 0, s_axi_araddr = 0, pushByte;
	logic [15:0] stackTopPointerIn, pcIn, popData, stackTopPointerOut, pcOut;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF, servedVector;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, globalEnable, irqHold, pushValid, popReq, stackWrite, pcLoad;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, nPush = 0;
	cier_unit u_dut (.*);
	cier_seq_model u_seq (.irqHold, .stall, .instrBoundary, .pcIn, .stackTopPointerIn, .popData);
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		nPush <= nPush + pushValid;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test;
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task end_of_test;
		if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tr, dn;
		logic [1:0] rs;
		logic [31:0] rd;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		dn = 0;
		while (!dn) begin
			#1;
			ta = s_axi_awready && s_axi_awvalid;
			tw = s_axi_wready && s_axi_wvalid;
			tr = s_axi_arready && s_axi_arvalid;
			dn = w ? s_axi_bvalid : s_axi_rvalid;
			rs = w ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge clock);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tr) s_axi_arvalid <= 0;
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		chk("resp", rs, (a > 8'h10) ? 2'b10 : 2'b00);
		if (!w && a <= 8'h10) chk("rdata", rd, d);
		@(posedge clock);
	endtask
	task ins(input logic s, input logic c);
		instrSeiExec <= s;
		instrCliExec <= c;
		@(posedge clock);
		instrSeiExec <= 0;
		instrCliExec <= 0;
		@(posedge clock);
	endtask
	task waitLoad(input logic [15:0] e, output int n);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (!pcLoad && n < 200);
		chk("pcLoad", pcLoad, 1);
		chk("pcOut", pcOut, e);
		@(posedge clock);
	endtask
	task fire(input logic [7:0] s, input logic [15:0] e, output int n);
		srcEvent <= s;
		@(posedge clock);
		srcEvent <= 0;
		waitLoad(e, n);
	endtask
	task ret;
		int n;
		instrRetiExec <= 1;
		@(posedge clock);
		instrRetiExec <= 0;
		waitLoad(popData, n);
		chk("gie", globalEnable, 1);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		bus(0, 8'h00, 0);
		bus(0, 8'h08, 0);
		bus(0, 8'h20, 0);
		bus(1, 8'h24, 1);
	endtask
	task t_hold;
		int p;
		bus(1, 8'h00, 0);
		ins(1, 0);
		p = nPush;
		srcEvent <= 8'h04;
		@(posedge clock);
		srcEvent <= 0;
		repeat (10) @(posedge clock);
		chk("noEntry", nPush, p);
		bus(0, 8'h04, 4);
		bus(1, 8'h04, 0);
		bus(0, 8'h04, 4);
		bus(1, 8'h04, 4);
		bus(0, 8'h04, 0);
	endtask
	task t_prio;
		int n;
		ins(0, 1);
		srcEvent <= 8'h0A;
		@(posedge clock);
		srcEvent <= 0;
		bus(1, 8'h00, 8'hFF);
		ins(1, 0);
		waitLoad(4, n);
		chk("seiGap", n, 5);
		bus(0, 8'h04, 8);
		bus(0, 8'h08, 32'h200);
		ret;
		waitLoad(8, n);
		chk("retGap", n, 5);
		bus(0, 8'h04, 0);
		ret;
	endtask
	task t_level;
		int n, p;
		ins(0, 1);
		bus(1, 8'h0C, 1);
		srcEvent <= 1;
		repeat (3) @(posedge clock);
		srcEvent <= 0;
		ins(1, 0);
		p = nPush;
		repeat (10) @(posedge clock);
		chk("noLevel", nPush, p);
		srcEvent <= 1;
		waitLoad(2, n);
		srcEvent <= 0;
		ret;
		bus(1, 8'h0C, 0);
	endtask
	task t_sleep;
		int a, b;
		bus(1, 8'h10, 3);
		fire(8'h10, 10, a);
		ret;
		coreSleeping <= 1;
		fire(8'h10, 10, b);
		coreSleeping <= 0;
		ret;
		chk("wake", b - a, 7);
	endtask
	task t_nest;
		int n;
		fire(8'h20, 12, n);
		instrGieWrite <= 1;
		instrGieValue <= 1;
		@(posedge clock);
		instrGieWrite <= 0;
		fire(8'h40, 14, n);
		ret;
		ret;
	endtask
	task t_stall;
		int n, p;
		p = nPush;
		stall <= 1;
		srcEvent <= 8'h80;
		@(posedge clock);
		srcEvent <= 0;
		repeat (8) @(posedge clock);
		chk("stall", nPush, p);
		stall <= 0;
		waitLoad(16, n);
		ret;
	endtask
	// Disable lands on the very edge at which the new flag would win
	task t_cli;
		int p;
		srcEvent <= 8'h80;
		@(posedge clock);
		srcEvent <= 0;
		repeat (2) @(posedge clock);
		p = nPush;
		ins(0, 1);
		repeat (8) @(posedge clock);
		chk("cliBlock", nPush, p);
		bus(0, 8'h04, 8'h80);
		bus(1, 8'h04, 8'h80);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		nrst <= 1;
		repeat (3) @(posedge clock);
		t_regs;
		t_hold;
		t_prio;
		t_level;
		t_sleep;
		t_nest;
		t_stall;
		t_cli;
		end_of_test;
	end
endmodule // tb_cpu_interrupt_entry_return
`default_nettype wire
